// >>> include/uedc_pkg.sv
// Constants and types for the endpoint data-flow command engine
// What this block does
// - Interrupt-source command returns two status bytes
// - Endpoint flags clear on status read; others on read
// - Three missed SOFs suspend; suspend change sets bit7
// - Bus reset resets, flags bit6, stays enabled
// - Select sets pointer to buffer start; optional byte
// - Status read returns byte, clears flag, marks read
// - Status byte: overrun, toggle, setup, error, success
// - Error code values follow the fixed table
// - Buffer reads return next byte, pointer increments
// - Buffer command returns pointer to buffer top
// - Buffer: reserved, length, payload; DMA skips two
// - DMA write sends only full buffer, or at end
// - No bound checks; main endpoint DMA switches bank
// - Received OUT sets full, NAK until cleared
// - Validate sets full; data sent on next IN
// - Status write stalls; SETUP unstalls control endpoint
// - Unstall or zero write reinitialises the endpoint
// - SETUP flushes IN, locks until both acknowledged
// - Resume command drives resume for 10 ms
// - Frame number read low byte first
// - Interrupt pin source chosen by SOF mode bits
// - Error-report mode chooses OK-only or all reports
package uedc_pkg;
    localparam int NEP = 6;
    localparam int BUF_LEN = 130;
    localparam int NBUF = 8;
    localparam int HDR_LEN = 2;
    localparam logic [7:0] CMD_SEL_LAST = 8'h05;
    localparam logic [7:0] CMD_EPS_BASE = 8'h40;
    localparam logic [7:0] CMD_EPS_LAST = 8'h45;
    localparam logic [7:0] CMD_BUF = 8'hF0;
    localparam logic [7:0] CMD_ACK = 8'hF1;
    localparam logic [7:0] CMD_CLR = 8'hF2;
    localparam logic [7:0] CMD_INT = 8'hF4;
    localparam logic [7:0] CMD_FRM = 8'hF5;
    localparam logic [7:0] CMD_RES = 8'hF6;
    localparam logic [7:0] CMD_VAL = 8'hFA;
    localparam int IRQ_BUSRST = 6;
    localparam int IRQ_SUSCHG = 7;
    localparam int SEL_FULL = 0;
    localparam int SEL_STALL = 1;
    localparam int ST_OVR = 7;
    localparam logic [1:0] SOF_MISS_LAST = 2'h2;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_PID_CHK = 4'h1;
    localparam logic [3:0] ERR_PID_UNK = 4'h2;
    localparam logic [3:0] ERR_UNEXP = 4'h3;
    localparam logic [3:0] ERR_TOK_CRC = 4'h4;
    localparam logic [3:0] ERR_DAT_CRC = 4'h5;
    localparam logic [3:0] ERR_TIMEOUT = 4'h6;
    localparam logic [3:0] ERR_EARLY_EOP = 4'h8;
    localparam logic [3:0] ERR_NAK = 4'h9;
    localparam logic [3:0] ERR_STALL = 4'hA;
    localparam logic [3:0] ERR_OVERFLOW = 4'hB;
    localparam logic [3:0] ERR_STUFF = 4'hD;
    localparam logic [3:0] ERR_DATA_PID = 4'hF;
    localparam int CLK_HZ = 20000000;
    localparam int RESUME_MS = 10;
    localparam int RESUME_CYC = CLK_HZ / 1000 * RESUME_MS;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {M_IDLE, M_SEL, M_EPS, M_INT0, M_INT1, M_BUF, M_FRM0, M_FRM1} uedc_mode_t;

    typedef struct packed {
        logic ok_tog;
        logic setup;
        logic [3:0] err;
        logic ok;
    } uedc_sie_st_t;

    typedef struct packed {
        uedc_mode_t mode;
        logic [2:0] ep;
        logic [2:0] tgt;
        logic [7:0] ptr;
        logic [7:0] irq_src;
        logic [NEP-1:0][7:0] lts;
        logic [NEP-1:0] full;
        logic [NEP-1:0] stall;
        logic [NEP-1:0] tog;
        logic [NEP-1:0] unread;
        logic lock;
        logic [1:0] acked;
        logic [1:0] miss;
        logic susp;
        logic irq;
        logic [17:0] res_cnt;
        logic [10:0] frame;
        logic fen;
        logic bank_w;
        logic bank_r;
        logic [7:0] dptr_w;
        logic [7:0] dptr_r;
        logic [7:0] dma_rdata;
    } uedc_state_t;

    localparam uedc_state_t ST_RST = uedc_state_t'({8'(HDR_LEN), 8'(HDR_LEN), 8'h00});
endpackage : uedc_pkg

// >>> design/usb_endpoint_dataflow_commands.sv
// Command engine with answer FIFO for the endpoint data flow
`timescale 1ns/1ps
`default_nettype none

module uedc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule : uedc_fifo

module uedc_top #(
    parameter int RESUME_CYCLES = uedc_pkg::RESUME_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hp_wr,
    input wire logic hp_a0,
    input wire logic [7:0] hp_wdata,
    input wire logic hp_rd,
    output logic hp_rd_ready,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    input wire logic cfg_report_all,
    input wire logic cfg_sof_only,
    input wire logic cfg_pin_sof,
    input wire logic sie_bus_reset,
    input wire logic sie_sof,
    input wire logic [10:0] sie_frame,
    input wire logic sie_sof_missed,
    input wire logic sie_activity,
    input wire logic sie_evt,
    input wire logic [2:0] sie_ep,
    input wire uedc_pkg::uedc_sie_st_t sie_st,
    input wire logic sie_rx_full,
    input wire logic sie_tx_done,
    input wire logic sie_setup,
    input wire logic sie_we,
    input wire logic [10:0] sie_addr,
    input wire logic [7:0] sie_wdata,
    output logic [7:0] sie_rdata,
    input wire logic dma_wr,
    input wire logic [7:0] dma_wdata,
    output logic dma_wr_ready,
    input wire logic dma_rd,
    output logic [7:0] dma_rdata,
    input wire logic transfer_done_n,
    output logic [5:0] ep_full,
    output logic [5:0] ep_stall,
    output logic [5:0] ep_toggle,
    output logic suspended,
    output logic resume_drive,
    output logic func_enabled,
    output logic irq
);
    import uedc_pkg::*;

    uedc_state_t s_q;
    uedc_state_t s_d;
    logic [7:0] mem [NBUF*BUF_LEN];
    logic push;
    logic fifo_ready;
    logic [7:0] pbyte;
    logic h_we;
    logic d_we;
    logic [10:0] h_addr;
    logic [10:0] dw_addr;
    logic [10:0] dr_addr;
    logic [7:0] dr_len;
    logic dr_ok;
    logic host_data_wr;
    logic [7:0] cmd;
    logic [2:0] e;

    function automatic logic [10:0] baddr(input logic [2:0] idx, input logic [7:0] p);
        baddr = 11'(idx) * 11'(BUF_LEN) + 11'(p);
    endfunction : baddr

    assign cmd = hp_wdata;
    assign host_data_wr = hp_wr & ~hp_a0 & (s_q.mode == M_BUF);
    assign h_addr = baddr(s_q.ep, s_q.ptr);
    // Main endpoint banks: bank 1 of OUT and IN sit in buffers 6 and 7
    assign dw_addr = baddr(s_q.bank_w ? 3'h7 : 3'h5, s_q.dptr_w);
    assign dr_addr = baddr(s_q.bank_r ? 3'h6 : 3'h4, s_q.dptr_r);
    assign dr_len = mem[baddr(s_q.bank_r ? 3'h6 : 3'h4, 8'h01)];
    // One memory write port for host and DMA; the host wins the slot
    assign dma_wr_ready = ~host_data_wr;
    assign d_we = dma_wr & dma_wr_ready;
    assign dr_ok = dma_rd & s_q.full[4];
    assign h_we = host_data_wr;
    assign hp_rd_ready = fifo_ready;
    assign e = sie_ep;

    always_comb begin
        s_d = s_q;
        push = 1'b0;
        pbyte = 8'h00;
        if (hp_wr && hp_a0) begin
            s_d.mode = M_IDLE;
            if (cmd <= CMD_SEL_LAST) begin
                s_d.ep = cmd[2:0];
                s_d.ptr = 8'h00;
                s_d.mode = M_SEL;
            end else if (cmd >= CMD_EPS_BASE && cmd <= CMD_EPS_LAST) begin
                s_d.tgt = cmd[2:0];
                s_d.mode = M_EPS;
            end else begin
                unique case (cmd)
                    CMD_INT: s_d.mode = M_INT0;
                    CMD_BUF: begin
                        s_d.ptr = 8'h00;
                        s_d.mode = M_BUF;
                    end
                    CMD_FRM: s_d.mode = M_FRM0;
                    CMD_RES: s_d.res_cnt = 18'(RESUME_CYCLES);
                    CMD_ACK: begin
                        if (s_q.ep < 3'h2) begin
                            s_d.acked[s_q.ep[0]] = 1'b1;
                        end
                        if (&s_d.acked) begin
                            s_d.lock = 1'b0;
                        end
                    end
                    CMD_CLR: begin
                        if (!s_q.lock) begin
                            s_d.full[s_q.ep] = 1'b0;
                        end
                    end
                    CMD_VAL: begin
                        if (!s_q.lock) begin
                            s_d.full[s_q.ep] = 1'b1;
                        end
                    end
                    default: s_d.mode = M_IDLE;
                endcase
            end
        end else if (hp_wr) begin
            unique case (s_q.mode)
                M_BUF: s_d.ptr = s_q.ptr + 8'h01;
                M_EPS: begin
                    s_d.stall[s_q.tgt] = hp_wdata[0];
                    if (!hp_wdata[0]) begin
                        s_d.full[s_q.tgt] = 1'b0;
                        s_d.tog[s_q.tgt] = 1'b0;
                    end
                    s_d.mode = M_IDLE;
                end
                default: s_d.mode = s_q.mode;
            endcase
        end else if (hp_rd && fifo_ready) begin
            push = 1'b1;
            unique case (s_q.mode)
                M_SEL: begin
                    pbyte[SEL_FULL] = s_q.full[s_q.ep];
                    pbyte[SEL_STALL] = s_q.stall[s_q.ep];
                    s_d.mode = M_IDLE;
                end
                M_EPS: begin
                    pbyte = s_q.lts[s_q.tgt];
                    s_d.lts[s_q.tgt] = 8'h00;
                    s_d.unread[s_q.tgt] = 1'b0;
                    s_d.irq_src[s_q.tgt] = 1'b0;
                    s_d.mode = M_IDLE;
                end
                M_INT0: begin
                    pbyte = s_q.irq_src;
                    s_d.irq_src[IRQ_SUSCHG] = 1'b0;
                    s_d.irq_src[IRQ_BUSRST] = 1'b0;
                    s_d.mode = M_INT1;
                end
                M_INT1: s_d.mode = M_IDLE;
                M_BUF: begin
                    pbyte = mem[h_addr];
                    s_d.ptr = s_q.ptr + 8'h01;
                end
                M_FRM0: begin
                    pbyte = s_q.frame[7:0];
                    s_d.mode = M_FRM1;
                end
                M_FRM1: begin
                    pbyte = {5'h00, s_q.frame[10:8]};
                    s_d.mode = M_IDLE;
                end
                default: pbyte = 8'h00;
            endcase
        end
        // DMA on the main endpoint, headers skipped, banks alternate
        if (d_we) begin
            s_d.dptr_w = s_q.dptr_w + 8'h01;
            if (s_q.dptr_w == 8'(BUF_LEN - 1) || !transfer_done_n) begin
                s_d.full[5] = 1'b1;
                s_d.bank_w = ~s_q.bank_w;
                s_d.dptr_w = 8'(HDR_LEN);
            end
        end
        if (dr_ok) begin
            s_d.dma_rdata = mem[dr_addr];
            s_d.dptr_r = s_q.dptr_r + 8'h01;
            if (s_q.dptr_r + 8'h01 >= dr_len + 8'(HDR_LEN)) begin
                s_d.full[4] = 1'b0;
                s_d.bank_r = ~s_q.bank_r;
                s_d.dptr_r = 8'(HDR_LEN);
            end
        end
        // Engine events come after host clears, so a set in the same cycle wins
        if (sie_tx_done) begin
            s_d.full[e] = 1'b0;
        end
        if (sie_rx_full) begin
            s_d.full[e] = 1'b1;
        end
        if (sie_evt && (sie_st.ok || cfg_report_all)) begin
            s_d.lts[e] = {s_d.unread[e], sie_st};
            s_d.unread[e] = 1'b1;
            s_d.irq_src[e] = 1'b1;
            if (sie_st.ok) begin
                s_d.tog[e] = ~sie_st.ok_tog;
            end
        end
        if (sie_setup) begin
            s_d.full[1] = 1'b0;
            s_d.lock = 1'b1;
            s_d.acked = 2'h0;
            if (s_q.stall[0] || s_q.stall[1]) begin
                s_d.stall[1:0] = 2'h0;
                s_d.tog[1:0] = 2'h0;
            end
        end
        if (sie_sof) begin
            s_d.frame = sie_frame;
            s_d.miss = 2'h0;
        end else if (sie_sof_missed && !s_q.susp) begin
            s_d.miss = s_q.miss + 2'h1;
            if (s_q.miss == SOF_MISS_LAST) begin
                s_d.susp = 1'b1;
                s_d.irq_src[IRQ_SUSCHG] = 1'b1;
                s_d.miss = 2'h0;
            end
        end
        if ((sie_sof || sie_activity) && s_q.susp) begin
            s_d.susp = 1'b0;
            s_d.irq_src[IRQ_SUSCHG] = 1'b1;
        end
        if (s_q.res_cnt != 18'h0 && !(hp_wr && hp_a0 && cmd == CMD_RES)) begin
            s_d.res_cnt = s_q.res_cnt - 18'h1;
        end
        if (sie_bus_reset) begin
            s_d = ST_RST;
            s_d.fen = 1'b1;
            s_d.irq_src[IRQ_BUSRST] = 1'b1;
        end
        // Pin source selection, SOF-only mode overrides pin mode
        if (cfg_sof_only) begin
            s_d.irq = sie_sof;
        end else begin
            s_d.irq = (|s_d.irq_src) | (cfg_pin_sof & sie_sof);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // No bounds checking: pointers past a buffer reach the next one
    always_ff @(posedge clk) begin
        if (h_we) begin
            mem[h_addr] <= hp_wdata;
        end
        if (d_we) begin
            mem[dw_addr] <= dma_wdata;
        end
        if (sie_we) begin
            mem[sie_addr] <= sie_wdata;
        end
        sie_rdata <= mem[sie_addr];
    end

    uedc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(pbyte),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    assign ep_full = s_q.full;
    assign ep_stall = s_q.stall;
    assign ep_toggle = s_q.tog;
    assign suspended = s_q.susp;
    assign resume_drive = s_q.res_cnt != 18'h0;
    assign func_enabled = s_q.fen;
    assign dma_rdata = s_q.dma_rdata;
    assign irq = s_q.irq;

    logic quiet;
    assign quiet = !sie_evt && !sie_rx_full && !sie_tx_done && !sie_setup && !sie_bus_reset;

    a_lts_read_clear: assert property (@(posedge clk) disable iff (rst)
        hp_rd && !hp_wr && fifo_ready && s_q.mode == M_EPS && quiet
        |=> !s_q.irq_src[$past(s_q.tgt)] && !s_q.unread[$past(s_q.tgt)])
        else $error("status read left flag set");
    a_suspend_third_miss: assert property (@(posedge clk) disable iff (rst)
        sie_sof_missed && !sie_sof && !sie_activity && !s_q.susp && s_q.miss == 2'h2 && !sie_bus_reset
        |=> s_q.susp && s_q.irq_src[7])
        else $error("no suspend after three misses");
    a_bus_reset_flag: assert property (@(posedge clk) disable iff (rst)
        sie_bus_reset |=> s_q.irq_src[6] && func_enabled && s_q.mode == M_IDLE && !s_q.susp)
        else $error("bus reset effect wrong");
    a_buf_ptr_step: assert property (@(posedge clk) disable iff (rst)
        hp_rd && !hp_wr && fifo_ready && s_q.mode == M_BUF && !sie_bus_reset
        |=> s_q.ptr == $past(s_q.ptr) + 8'h01 ##1 rd_valid)
        else $error("buffer pointer did not step");
    a_bufcmd_ptr_top: assert property (@(posedge clk) disable iff (rst)
        hp_wr && hp_a0 && hp_wdata == 8'hF0 && !sie_bus_reset |=> s_q.ptr == 8'h00 && s_q.mode == M_BUF)
        else $error("buffer command kept pointer");
    a_setup_locks: assert property (@(posedge clk) disable iff (rst)
        sie_setup && !sie_bus_reset |=> s_q.lock && !ep_full[1])
        else $error("setup did not lock");
    a_lock_blocks_val: assert property (@(posedge clk) disable iff (rst)
        s_q.lock && hp_wr && hp_a0 && hp_wdata == 8'hFA && s_q.ep == 3'h1 && quiet
        |=> !ep_full[1])
        else $error("validate passed while locked");
    a_resume_len: assert property (@(posedge clk) disable iff (rst)
        hp_wr && hp_a0 && hp_wdata == 8'hF6 && !sie_bus_reset |=> resume_drive [*8])
        else $error("resume drive too short");
    a_sof_only_irq: assert property (@(posedge clk) disable iff (rst)
        cfg_sof_only && !sie_sof |=> !irq)
        else $error("irq outside sof in sof-only mode");
    a_rx_sets_full: assert property (@(posedge clk) disable iff (rst)
        sie_rx_full && !sie_bus_reset && !(sie_setup && sie_ep == 3'h1) |=> ep_full[$past(sie_ep)])
        else $error("received packet did not set full");

    c_status_read: cover property (@(posedge clk) disable iff (rst)
        sie_evt ##[1:20] (hp_rd && s_q.mode == M_EPS));
    c_suspend: cover property (@(posedge clk) disable iff (rst) $rose(s_q.susp));
    c_fifo_full: cover property (@(posedge clk) disable iff (rst) hp_rd && !fifo_ready);
endmodule : uedc_top

`default_nettype wire

// >>> dv/uedc_mcu.sv
// Microcontroller model on the parallel command port
`timescale 1ns/1ps
`default_nettype none
module uedc_mcu (
    input wire logic clk,
    output logic hp_wr,
    output logic hp_a0,
    output logic [7:0] hp_wdata,
    output logic hp_rd,
    output logic rd_ready,
    input wire logic hp_rd_ready,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);
    initial begin
        hp_wr = 1'b0;
        hp_a0 = 1'b0;
        hp_wdata = 8'h00;
        hp_rd = 1'b0;
        rd_ready = 1'b0;
    end
    // Bus inverted after release so a stale byte never looks valid
    task automatic put(input logic a0, input logic [7:0] d);
        hp_a0 = a0;
        hp_wdata = d;
        hp_wr = 1'b1;
        @(negedge clk);
        hp_wr = 1'b0;
        hp_wdata = ~d;
        @(negedge clk);
    endtask : put
    task automatic req();
        int n;
        n = 0;
        while (hp_rd_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        hp_rd = 1'b1;
        @(negedge clk);
        hp_rd = 1'b0;
        @(negedge clk);
    endtask : req
    // Bounded wait; ok low means the answer never came
    task automatic pop(output logic [7:0] d, output bit ok);
        int n;
        n = 0;
        while (rd_valid !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        ok = n < 40;
        d = rd_data;
        rd_ready = 1'b1;
        @(negedge clk);
        rd_ready = 1'b0;
        @(negedge clk);
    endtask : pop
endmodule : uedc_mcu
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the endpoint data-flow command engine
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uedc_pkg::*;
    localparam int RES_CYC = 20;
    localparam logic [7:0] P_BRST = 8'h80, P_SOF = 8'h40, P_MISS = 8'h20, P_ACT = 8'h10;
    localparam logic [7:0] P_RX = 8'h08, P_TX = 8'h04, P_SET = 8'h02, P_EVT = 8'h01;
    logic clk, rst, hp_wr, hp_a0, hp_rd, hp_rd_ready, rd_valid, rd_ready;
    logic [7:0] hp_wdata, rd_data, sie_wdata, sie_rdata, dma_wdata, dma_rdata, pl;
    logic cfg_report_all, cfg_sof_only, cfg_pin_sof, sie_bus_reset, sie_sof, sie_sof_missed, sie_activity;
    logic sie_evt, sie_rx_full, sie_tx_done, sie_setup, sie_we, dma_wr, dma_wr_ready, dma_rd, transfer_done_n;
    logic [10:0] sie_frame, sie_addr;
    logic [2:0] sie_ep;
    uedc_sie_st_t sie_st;
    logic [5:0] ep_full, ep_stall, ep_toggle;
    logic suspended, resume_drive, func_enabled, irq;
    int bad_count = 0, total_checks = 0, res_seen = 0;
    // Rows: endpoint, status pattern fed in, status byte expected back
    logic [19:0] rows [14] = '{20'h0_21_21, 20'h1_02_02, 20'h2_04_04, 20'h3_06_06, 20'h4_08_08, 20'h5_0A_0A,
        20'h0_0C_0C, 20'h1_10_10, 20'h2_12_12, 20'h3_14_14, 20'h4_16_16, 20'h5_1A_1A, 20'h0_1E_1E, 20'h3_41_41};
    logic [2:0] modes [3] = '{3'b011, 3'b101, 3'b000};
    logic [7:0] bytes [8] = '{8'h00, 8'h06, 8'hAA, 8'hBB, 8'hCC, 8'h11, 8'h22, 8'h33};
    assign {sie_bus_reset, sie_sof, sie_sof_missed, sie_activity, sie_rx_full, sie_tx_done, sie_setup, sie_evt} = pl;

    uedc_top #(.RESUME_CYCLES(RES_CYC)) u_uedc_top (
        .clk, .rst, .hp_wr, .hp_a0, .hp_wdata, .hp_rd, .hp_rd_ready, .rd_valid, .rd_ready, .rd_data,
        .cfg_report_all, .cfg_sof_only, .cfg_pin_sof, .sie_bus_reset, .sie_sof, .sie_frame, .sie_sof_missed,
        .sie_activity, .sie_evt, .sie_ep, .sie_st, .sie_rx_full, .sie_tx_done, .sie_setup, .sie_we, .sie_addr,
        .sie_wdata, .sie_rdata, .dma_wr, .dma_wdata, .dma_wr_ready, .dma_rd, .dma_rdata, .transfer_done_n,
        .ep_full, .ep_stall, .ep_toggle, .suspended, .resume_drive, .func_enabled, .irq);
    uedc_mcu u_uedc_mcu (.clk, .hp_wr, .hp_a0, .hp_wdata, .hp_rd, .rd_ready, .hp_rd_ready, .rd_valid, .rd_data);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (resume_drive === 1'b1) res_seen <= res_seen + 1;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic tick(input int k = 1);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic cmd(input logic [7:0] c);
        u_uedc_mcu.put(1'b1, c);
    endtask : cmd
    task automatic wr(input logic [7:0] d);
        u_uedc_mcu.put(1'b0, d);
    endtask : wr
    task automatic popc(input string name, input logic [7:0] exp);
        logic [7:0] d;
        bit got;
        u_uedc_mcu.pop(d, got);
        if (!got) begin
            bad_count++;
            print_verdict();
        end else begin
            chk(name, 16'(d), 16'(exp));
        end
    endtask : popc
    task automatic rdc(input string name, input logic [7:0] exp);
        u_uedc_mcu.req();
        popc(name, exp);
    endtask : rdc
    task automatic pulse(input logic [7:0] m);
        pl = m;
        tick();
        pl = 8'h00;
        tick();
    endtask : pulse
    // Bytes go out back to back; end of transfer marks only the last one
    task automatic dmaw(input int cnt, input logic eot);
        for (int i = 0; i < cnt; i++) begin
            dma_wdata = 8'(i);
            transfer_done_n = !(eot && i == cnt - 1);
            dma_wr = 1'b1;
            tick();
        end
        dma_wr = 1'b0;
        transfer_done_n = 1'b1;
        tick();
    endtask : dmaw

    initial begin
        {rst, pl, cfg_report_all, cfg_sof_only, cfg_pin_sof, sie_we, dma_wr, dma_rd} = '1;
        {pl, cfg_report_all, cfg_sof_only, cfg_pin_sof, sie_we, dma_wr, dma_rd} = '0;
        {sie_frame, sie_addr, sie_ep, sie_st, sie_wdata, dma_wdata} = '0;
        transfer_done_n = 1'b1;
        tick(10);
        rst = 1'b0;
        chk("after reset", {ep_full, func_enabled, irq, suspended, resume_drive, hp_rd_ready, rd_valid}, 12'h002);
        pulse(P_BRST);
        chk("bus reset", {func_enabled, irq}, 2'h3);
        cmd(CMD_INT);
        rdc("irq byte1", 8'h40);
        rdc("irq byte2", 8'h00);
        chk("irq cleared", irq, 1'b0);
        cfg_report_all = 1'b1;
        for (int i = 0; i < 14; i++) begin
            sie_ep = rows[i][18:16];
            sie_st = uedc_sie_st_t'(rows[i][14:8]);
            pulse(P_EVT);
            cmd(CMD_EPS_BASE | {5'h00, rows[i][18:16]});
            rdc("last status", rows[i][7:0]);
        end
        cmd(CMD_INT);
        rdc("irq after reads", 8'h00);
        rdc("irq byte2", 8'h00);
        cfg_report_all = 1'b0;
        sie_ep = 3'h2;
        sie_st = uedc_sie_st_t'(7'h12);
        pulse(P_EVT);
        cmd(CMD_INT);
        rdc("nak hidden", 8'h00);
        rdc("irq byte2", 8'h00);
        sie_st = uedc_sie_st_t'(7'h01);
        pulse(P_EVT);
        pulse(P_EVT);
        for (int k = 0; k < 2; k++) begin
            cmd(CMD_INT);
            rdc("ep flag kept", 8'h04);
            rdc("irq byte2", 8'h00);
        end
        cmd(8'h42);
        rdc("overrun", 8'h81);
        repeat (3) pulse(P_MISS);
        chk("suspend", suspended, 1'b1);
        cmd(CMD_INT);
        rdc("suspend change", 8'h80);
        rdc("irq byte2", 8'h00);
        pulse(P_ACT);
        chk("awake", suspended, 1'b0);
        cmd(CMD_INT);
        rdc("wake change", 8'h80);
        rdc("irq byte2", 8'h00);
        sie_frame = 11'h5A3;
        for (int m = 0; m < 3; m++) begin
            {cfg_sof_only, cfg_pin_sof} = modes[m][2:1];
            pl = P_SOF;
            tick();
            chk("sof irq", irq, modes[m][0]);
            pl = 8'h00;
            tick();
            chk("sof irq gone", irq, 1'b0);
        end
        sie_ep = 3'h0;
        cfg_sof_only = 1'b1;
        pulse(P_EVT);
        chk("sof only masks", irq, 1'b0);
        cfg_sof_only = 1'b0;
        tick();
        chk("normal irq", irq, 1'b1);
        cmd(CMD_EPS_BASE);
        rdc("status ep0", 8'h01);
        cmd(CMD_FRM);
        rdc("frame low", 8'hA3);
        rdc("frame high", 8'h05);
        cmd(8'h01);
        rdc("select empty", 8'h00);
        cmd(CMD_BUF);
        for (int i = 0; i < 8; i++) wr(bytes[i]);
        cmd(CMD_VAL);
        chk("validate", ep_full[1], 1'b1);
        cmd(8'h01);
        rdc("select full", 8'h01);
        cmd(CMD_BUF);
        rdc("reserved", 8'h00);
        cmd(CMD_FRM);
        rdc("frame low", 8'hA3);
        cmd(CMD_BUF);
        for (int i = 0; i < 8; i++) u_uedc_mcu.req();
        chk("fifo full", hp_rd_ready, 1'b0);
        for (int i = 0; i < 8; i++) popc("buffer byte", bytes[i]);
        chk("fifo drained", {rd_valid, hp_rd_ready}, 2'h1);
        sie_addr = 11'd132;
        tick(2);
        chk("payload place", sie_rdata, 8'hAA);
        sie_ep = 3'h4;
        pulse(P_RX);
        chk("rx full", ep_full[4], 1'b1);
        cmd(8'h44);
        wr(8'h01);
        chk("stall", ep_stall[4], 1'b1);
        cmd(8'h04);
        rdc("select stall", 8'h03);
        for (int k = 0; k < 2; k++) begin
            cmd(8'h44);
            wr(8'h00);
            chk("reinit", {ep_full[4], ep_stall[4], ep_toggle[4]}, 3'h0);
            pulse(P_RX);
        end
        cmd(8'h44);
        wr(8'h00);
        cmd(CMD_EPS_BASE);
        wr(8'h01);
        pulse(P_SET);
        chk("setup unstall", ep_stall[0], 1'b0);
        chk("setup flush", ep_full[1], 1'b0);
        sie_ep = 3'h0;
        pulse(P_RX);
        cmd(8'h00);
        cmd(CMD_CLR);
        cmd(8'h01);
        cmd(CMD_VAL);
        chk("locked", ep_full[1:0], 2'h1);
        cmd(8'h00);
        cmd(CMD_ACK);
        cmd(8'h01);
        cmd(CMD_ACK);
        cmd(CMD_VAL);
        cmd(8'h00);
        cmd(CMD_CLR);
        chk("unlocked", ep_full[1:0], 2'h2);
        cmd(8'h77);
        wr(8'h55);
        chk("undefined", {ep_full, ep_stall}, 12'h080);
        rdc("stray read", 8'h00);
        cmd(CMD_RES);
        for (int n = 0; n < 60 && resume_drive !== 1'b0; n++) tick();
        chk("resume length", 16'(res_seen), 16'(RES_CYC));
        pulse(P_BRST);
        chk("dma ready", dma_wr_ready, 1'b1);
        dmaw(3, 1'b1);
        chk("eot send", ep_full[5], 1'b1);
        sie_ep = 3'h5;
        pulse(P_TX);
        chk("sent", ep_full[5], 1'b0);
        dmaw(127, 1'b0);
        chk("part full", ep_full[5], 1'b0);
        dmaw(1, 1'b0);
        chk("buffer full", ep_full[5], 1'b1);
        cmd(8'h04);
        cmd(CMD_BUF);
        for (int i = 0; i < 8; i++) wr(bytes[i]);
        cmd(CMD_VAL);
        dma_rd = 1'b1;
        tick();
        dma_rd = 1'b0;
        chk("dma read", dma_rdata, 8'hAA);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
